// [usb_frame_timing_counters.sv]
// Purpose: frame period, bit times left and frame number of a full-speed host
// Assumes: bit_tick is a one-cycle pulse per bit time; running_state is a level
// Notes:   register reads answer one cycle after sel; hardware beats writes
// Operation
// - load packet budget at every frame start
// - budget counter limits bits per transaction
// - period field plus one gives bit times between SOFs
// - period resets to nominal 11,999
// - bit times left is 14-bit down counter
// - count down one per bit time while running
// - at zero reload period on next bit time
// - copy toggle into countdown copy at zero
// - entering running reloads counter from period
// - frame number is a 16-bit counter
// - frame number increments on reload and entry
// - write number to shared area, then flag
`timescale 1ns/1ps
module usb_frame_timing_counters (
    // clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  nrst,
    // register window
    input  wire frame_timing_pkg::reg_req_s            reg_req,
    output logic      [31:0]                           reg_rdata_q,
    output logic                                       reg_ack_q,
    // bus timing
    input  wire logic                                  bit_tick,
    input  wire logic                                  running_state,
    input  wire logic                                  pkt_bit,
    output logic                                       sof_pulse_q,
    // packet budget
    output logic      [frame_timing_pkg::BUDGET_W-1:0] packet_budget_q,
    output logic                                       packet_budget_ok_q,
    // shared area write
    output logic                                       sca_wr_req_q,
    output logic      [frame_timing_pkg::COUNT_W-1:0]  sca_wr_data_q,
    input  wire logic                                  sca_wr_done,
    output logic                                       desc_fetch_ok_q,
    // status
    output logic                                       sof_written_flag_q,
    input  wire logic                                  sof_flag_clr
);
    import frame_timing_pkg::*;

    logic [PERIOD_W-1:0] frame_period_bits_q, frame_period_bits_d;
    logic [BUDGET_W-1:0] packet_bit_budget_q, packet_bit_budget_d;
    logic                period_update_toggle_q, period_update_toggle_d;
    logic [PERIOD_W-1:0] bit_times_left_q, bit_times_left_d;
    logic                countdown_toggle_copy_q, countdown_toggle_copy_d;
    logic [COUNT_W-1:0]  sof_count_q, sof_count_d;
    logic                running_prev_q;
    logic                run_rise, zero_reload, frame_start;
    logic                wr_period, wr_left, wr_count;
    logic [31:0]         reg_rdata_d;
    logic                sof_pulse_d;

    // frame boundary events
    assign run_rise    = running_state && !running_prev_q;
    assign zero_reload = running_state && bit_tick && bit_times_left_q == LEFT_RST;
    assign frame_start = run_rise || zero_reload;
    assign wr_period   = reg_req.sel && reg_req.wr && reg_req.addr == OFS_PERIOD;
    assign wr_left     = reg_req.sel && reg_req.wr && reg_req.addr == OFS_LEFT;
    assign wr_count    = reg_req.sel && reg_req.wr && reg_req.addr == OFS_COUNT;

    // next values of configuration and counters
    always_comb begin
        frame_period_bits_d     = frame_period_bits_q;
        packet_bit_budget_d     = packet_bit_budget_q;
        period_update_toggle_d  = period_update_toggle_q;
        bit_times_left_d        = bit_times_left_q;
        countdown_toggle_copy_d = countdown_toggle_copy_q;
        sof_count_d             = sof_count_q;
        if (wr_period) begin
            frame_period_bits_d    = reg_req.wdata[PERIOD_LSB +: PERIOD_W];
            packet_bit_budget_d    = reg_req.wdata[BUDGET_LSB +: BUDGET_W];
            period_update_toggle_d = reg_req.wdata[TOGGLE_BIT];
        end
        if (wr_left) begin
            bit_times_left_d        = reg_req.wdata[PERIOD_LSB +: PERIOD_W];
            countdown_toggle_copy_d = reg_req.wdata[TOGGLE_BIT];
        end
        if (wr_count) begin
            sof_count_d = reg_req.wdata[COUNT_W-1:0];
        end
        if (frame_start) begin
            bit_times_left_d = frame_period_bits_q;
            sof_count_d      = sof_count_q + 16'h0001;
        end else if (running_state && bit_tick) begin
            bit_times_left_d = bit_times_left_q - 14'h0001;
        end
        if (zero_reload) begin
            countdown_toggle_copy_d = period_update_toggle_q;
        end
    end

    // configuration and counter registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_period_bits_q     <= PERIOD_RST;
            packet_bit_budget_q     <= BUDGET_RST;
            period_update_toggle_q  <= TOGGLE_RST;
            bit_times_left_q        <= LEFT_RST;
            countdown_toggle_copy_q <= TOGGLE_RST;
            sof_count_q             <= COUNT_RST;
            running_prev_q          <= 1'b0;
        end else begin
            frame_period_bits_q     <= frame_period_bits_d;
            packet_bit_budget_q     <= packet_bit_budget_d;
            period_update_toggle_q  <= period_update_toggle_d;
            bit_times_left_q        <= bit_times_left_d;
            countdown_toggle_copy_q <= countdown_toggle_copy_d;
            sof_count_q             <= sof_count_d;
            running_prev_q          <= running_state;
        end
    end

    // read mux, reserved bits read zero
    always_comb begin
        reg_rdata_d = RDATA_RST;
        if (reg_req.sel && !reg_req.wr) begin
            case (reg_req.addr)
                OFS_PERIOD: begin
                    reg_rdata_d[PERIOD_LSB +: PERIOD_W] = frame_period_bits_q;
                    reg_rdata_d[BUDGET_LSB +: BUDGET_W] = packet_bit_budget_q;
                    reg_rdata_d[TOGGLE_BIT]             = period_update_toggle_q;
                end
                OFS_LEFT: begin
                    reg_rdata_d[PERIOD_LSB +: PERIOD_W] = bit_times_left_q;
                    reg_rdata_d[TOGGLE_BIT]             = countdown_toggle_copy_q;
                end
                OFS_COUNT: begin
                    reg_rdata_d[COUNT_W-1:0] = sof_count_q;
                end
                default: begin
                    reg_rdata_d = RDATA_RST;
                end
            endcase
        end
        sof_pulse_d = frame_start;
    end

    // read answer and start of frame strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_q <= RDATA_RST;
            reg_ack_q   <= 1'b0;
            sof_pulse_q <= 1'b0;
        end else begin
            reg_rdata_q <= reg_rdata_d;
            reg_ack_q   <= reg_req.sel;
            sof_pulse_q <= sof_pulse_d;
        end
    end

    // largest data packet counter
    packet_budget_counter u_budget (
        .clk         (clk),
        .nrst        (nrst),
        .load        (frame_start),
        .load_val    (packet_bit_budget_q),
        .consume     (pkt_bit),
        .budget_q    (packet_budget_q),
        .budget_ok_q (packet_budget_ok_q)
    );

    sca_state_e          sca_state_q, sca_state_d;
    logic                sca_wr_req_d, desc_fetch_ok_d, sof_written_flag_d;
    logic [COUNT_W-1:0]  sca_wr_data_d;

    // shared area write, then flag and descriptor fetch in the same cycle
    always_comb begin
        sca_state_d        = sca_state_q;
        sca_wr_req_d       = sca_wr_req_q;
        sca_wr_data_d      = sca_wr_data_q;
        desc_fetch_ok_d    = desc_fetch_ok_q;
        sof_written_flag_d = sof_written_flag_q && !sof_flag_clr;
        case (sca_state_q)
            SCA_IDLE, SCA_DONE: begin
                sca_state_d = sca_state_q;
            end
            SCA_WRITE: begin
                if (sca_wr_done) begin
                    sca_state_d        = SCA_DONE;
                    sca_wr_req_d       = 1'b0;
                    desc_fetch_ok_d    = 1'b1;
                    sof_written_flag_d = 1'b1;
                end
            end
            default: begin
                sca_state_d  = SCA_IDLE;
                sca_wr_req_d = 1'b0;
            end
        endcase
        if (frame_start) begin
            sca_state_d     = SCA_WRITE;
            sca_wr_req_d    = 1'b1;
            sca_wr_data_d   = sof_count_d;
            desc_fetch_ok_d = 1'b0;
        end
    end

    // sequencer registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sca_state_q        <= SCA_IDLE;
            sca_wr_req_q       <= 1'b0;
            sca_wr_data_q      <= COUNT_RST;
            desc_fetch_ok_q    <= 1'b0;
            sof_written_flag_q <= 1'b0;
        end else begin
            sca_state_q        <= sca_state_d;
            sca_wr_req_q       <= sca_wr_req_d;
            sca_wr_data_q      <= sca_wr_data_d;
            desc_fetch_ok_q    <= desc_fetch_ok_d;
            sof_written_flag_q <= sof_written_flag_d;
        end
    end

    property p_count_down;
        @(posedge clk) disable iff (!nrst)
        (running_state && bit_tick && !frame_start && !wr_left)
            |=> bit_times_left_q == $past(bit_times_left_q) - 14'h0001;
    endproperty
    a_count_down: assert property (p_count_down) else $error("counter did not step down");

    property p_zero_reload;
        @(posedge clk) disable iff (!nrst)
        zero_reload |=> bit_times_left_q == $past(frame_period_bits_q) && sof_pulse_q;
    endproperty
    a_zero_reload: assert property (p_zero_reload) else $error("no reload at zero");

    property p_toggle_copy;
        @(posedge clk) disable iff (!nrst)
        zero_reload |=> countdown_toggle_copy_q == $past(period_update_toggle_q);
    endproperty
    a_toggle_copy: assert property (p_toggle_copy) else $error("toggle not copied");

    property p_enter_run;
        @(posedge clk) disable iff (!nrst)
        $rose(running_state) |=> bit_times_left_q == $past(frame_period_bits_q);
    endproperty
    a_enter_run: assert property (p_enter_run) else $error("no reload on entry");

    property p_number_step;
        @(posedge clk) disable iff (!nrst)
        frame_start |=> sof_count_q == $past(sof_count_q) + 16'h0001;
    endproperty
    a_number_step: assert property (p_number_step) else $error("frame number not advanced");

    property p_sca_order;
        @(posedge clk) disable iff (!nrst)
        frame_start |=> sca_wr_req_q && !desc_fetch_ok_q && sca_wr_data_q == sof_count_q;
    endproperty
    a_sca_order: assert property (p_sca_order) else $error("shared area write out of order");

    property p_flag_set;
        @(posedge clk) disable iff (!nrst)
        (sca_wr_req_q && sca_wr_done && !frame_start)
            |=> sof_written_flag_q && desc_fetch_ok_q && !sca_wr_req_q;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set after write");

    property p_idle_hold;
        @(posedge clk) disable iff (!nrst)
        (!running_state && !wr_left) |=> $stable(bit_times_left_q);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("counter moved while stopped");

endmodule : usb_frame_timing_counters

// [frame_timing_pkg.sv]
// Purpose: shared constants and types for the frame timing counters
// Assumes: byte offsets inside the controller's register window
// Notes:   one bit_tick pulse marks one bit time
package frame_timing_pkg;

    // register offsets inside the window
    localparam logic [7:0]  OFS_PERIOD    = 8'h34;
    localparam logic [7:0]  OFS_LEFT      = 8'h38;
    localparam logic [7:0]  OFS_COUNT     = 8'h3C;

    // field positions and widths
    localparam int          PERIOD_LSB    = 0;
    localparam int          PERIOD_W      = 14;
    localparam int          BUDGET_LSB    = 16;
    localparam int          BUDGET_W      = 15;
    localparam int          TOGGLE_BIT    = 31;
    localparam int          COUNT_W       = 16;

    // reset values
    localparam logic [13:0] PERIOD_RST    = 14'h2EDF;
    localparam logic [14:0] BUDGET_RST    = 15'h0000;
    localparam logic [13:0] LEFT_RST      = 14'h0000;
    localparam logic [15:0] COUNT_RST     = 16'h0000;
    localparam logic        TOGGLE_RST    = 1'b0;
    localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

    // register access request
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_s;

    // shared area write sequencer
    typedef enum logic [1:0] {
        SCA_IDLE  = 2'b00,
        SCA_WRITE = 2'b01,
        SCA_DONE  = 2'b10
    } sca_state_e;

endpackage : frame_timing_pkg

// [packet_budget_counter.sv]
// Purpose: largest data packet counter, reloaded at every frame start
// Assumes: consume pulses once per data bit moved on the bus
// Notes:   load wins over consume in the same cycle
`timescale 1ns/1ps
module packet_budget_counter (
    // clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 nrst,
    // control
    input  wire logic                                 load,
    input  wire logic [frame_timing_pkg::BUDGET_W-1:0] load_val,
    input  wire logic                                 consume,
    // state
    output logic      [frame_timing_pkg::BUDGET_W-1:0] budget_q,
    output logic                                      budget_ok_q
);
    import frame_timing_pkg::*;

    logic [BUDGET_W-1:0] budget_d;
    logic                budget_ok_d;

    // next budget value
    always_comb begin
        budget_d = budget_q;
        if (load) begin
            budget_d = load_val;
        end else if (consume && budget_q != BUDGET_RST) begin
            budget_d = budget_q - 15'h0001;
        end
        budget_ok_d = (budget_d != BUDGET_RST);
    end

    // budget registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            budget_q    <= BUDGET_RST;
            budget_ok_q <= 1'b0;
        end else begin
            budget_q    <= budget_d;
            budget_ok_q <= budget_ok_d;
        end
    end

    property p_budget_load;
        @(posedge clk) disable iff (!nrst)
        load |=> budget_q == $past(load_val);
    endproperty
    a_budget_load: assert property (p_budget_load) else $error("budget not loaded");

    property p_budget_use;
        @(posedge clk) disable iff (!nrst)
        (!load && consume && budget_q != 15'h0000)
            |=> budget_q == $past(budget_q) - 15'h0001 && budget_ok_q == (budget_q != 15'h0000);
    endproperty
    a_budget_use: assert property (p_budget_use) else $error("budget not consumed");

endmodule : packet_budget_counter

// [usb_frame_timing_counters_tb.sv]
// Purpose: self-checking bench for the frame timing counters
// Assumes: a period field of 2 (3 bit times per frame) keeps frames short; one bit_tick per pulse call with TICK
// Notes:   inputs change by non-blocking assignment at the clk rising edge
`timescale 1ns/1ps
module usb_frame_timing_counters_tb;
    import frame_timing_pkg::*;

    // pulse masks over {bit_tick, pkt_bit, sca_wr_done, sof_flag_clr}
    localparam logic [3:0] TICK = 4'h8;
    localparam logic [3:0] PKT  = 4'h4;
    localparam logic [3:0] DONE = 4'h2;
    localparam logic [3:0] CLR  = 4'h1;

    logic                clk, nrst, reg_ack_q, bit_tick, running_state, pkt_bit, sof;
    logic                sof_pulse_q, packet_budget_ok_q, sca_wr_req_q, sca_wr_done;
    logic                desc_fetch_ok_q, sof_written_flag_q, sof_flag_clr;
    reg_req_s            reg_req;
    logic [31:0]         reg_rdata_q, rd;
    logic [BUDGET_W-1:0] packet_budget_q;
    logic [COUNT_W-1:0]  sca_wr_data_q;
    int                  n_mismatch, checked;

    // device under test
    usb_frame_timing_counters u_dut (
        .clk, .nrst, .reg_req, .reg_rdata_q, .reg_ack_q, .bit_tick, .running_state,
        .pkt_bit, .sof_pulse_q, .packet_budget_q, .packet_budget_ok_q, .sca_wr_req_q,
        .sca_wr_data_q, .sca_wr_done, .desc_fetch_ok_q, .sof_written_flag_q, .sof_flag_clr
    );

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask : check

    // one register access, answer taken one cycle after sel
    task automatic reg_acc(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge clk);
        reg_req <= '{sel: 1'b1, wr: wr, addr: addr, wdata: wdata};
        @(posedge clk);
        reg_req <= '0;
        #1;
        rd = reg_rdata_q;
        check(32'(reg_ack_q), 32'h1, "ack");
    endtask : reg_acc

    // read and compare
    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input string what);
        reg_acc(1'b0, addr, 32'h0000_0000);
        check(rd, exp, what);
    endtask : rd_chk

    // one-cycle pulse on a chosen input; sof sampled after it lands
    task automatic pulse(input logic [3:0] which);
        @(posedge clk);
        {bit_tick, pkt_bit, sca_wr_done, sof_flag_clr} <= which;
        @(posedge clk);
        {bit_tick, pkt_bit, sca_wr_done, sof_flag_clr} <= 4'h0;
        #1;
        sof = sof_pulse_q;
    endtask : pulse

    // reset images and unmapped read
    task automatic t_reset();
        rd_chk(OFS_PERIOD, 32'h0000_2EDF, "period reset");
        rd_chk(OFS_LEFT, 32'h0000_0000, "left reset");
        rd_chk(OFS_COUNT, 32'h0000_0000, "count reset");
        rd_chk(8'h40, 32'h0000_0000, "unmapped");
        reg_acc(1'b1, OFS_PERIOD, 32'h0005_0002);
        rd_chk(OFS_PERIOD, 32'h0005_0002, "period fields");
    endtask : t_reset

    // entering running is a frame boundary
    task automatic t_entry();
        @(posedge clk);
        running_state <= 1'b1;
        @(posedge clk);
        #1;
        check(32'(sof_pulse_q), 32'h1, "entry sof");
        check(32'(packet_budget_q), 32'h5, "entry budget");
        check({sca_wr_req_q, 15'h0, sca_wr_data_q}, 32'h8000_0001, "entry sca");
        rd_chk(OFS_LEFT, 32'h0000_0002, "entry reload");
        rd_chk(OFS_COUNT, 32'h0000_0001, "entry count");
        pulse(DONE);
        check({29'h0, sca_wr_req_q, desc_fetch_ok_q, sof_written_flag_q}, 32'h3, "sca done");
        pulse(CLR);
        check(32'(sof_written_flag_q), 32'h0, "flag clear");
    endtask : t_entry

    // budget consumption down to zero, saturating
    task automatic t_budget();
        repeat (4) pulse(PKT);
        check({packet_budget_ok_q, 16'h0, packet_budget_q}, 32'h8000_0001, "budget 1");
        repeat (2) pulse(PKT);
        check({packet_budget_ok_q, 16'h0, packet_budget_q}, 32'h0000_0000, "budget 0");
    endtask : t_budget

    // countdown, reload, toggle copy and frame number
    task automatic t_frame();
        reg_acc(1'b1, OFS_PERIOD, 32'h8005_0002);
        pulse(TICK);
        check(32'(sof), 32'h0, "no sof");
        rd_chk(OFS_LEFT, 32'h0000_0001, "left 1");
        pulse(TICK);
        rd_chk(OFS_LEFT, 32'h0000_0000, "left 0");
        pulse(TICK);
        check(32'(sof), 32'h1, "sof at reload");
        @(posedge clk);
        #1;
        check(32'(sof_pulse_q), 32'h0, "sof one cycle");
        check({sca_wr_req_q, desc_fetch_ok_q, 14'h0, sca_wr_data_q}, 32'h8000_0002, "sca");
        check(32'(packet_budget_q), 32'h5, "budget reload");
        rd_chk(OFS_LEFT, 32'h8000_0002, "reload and copy");
        rd_chk(OFS_COUNT, 32'h0000_0002, "count 2");
    endtask : t_frame

    // frame number wrap, hold when stopped, period back to nominal after a reset while stopped, then rewritten
    task automatic t_wrap();
        logic [31:0] saved;
        reg_acc(1'b1, OFS_COUNT, 32'h0000_FFFF);
        rd_chk(OFS_COUNT, 32'h0000_FFFF, "count 16 bits");
        repeat (3) pulse(TICK);
        check(32'(sca_wr_data_q), 32'h0, "wrap data");
        rd_chk(OFS_COUNT, 32'h0000_0000, "wrap");
        @(posedge clk);
        running_state <= 1'b0;
        pulse(TICK);
        rd_chk(OFS_LEFT, 32'h8000_0002, "hold stopped");
        rd_chk(OFS_PERIOD, 32'h8005_0002, "period saved");
        saved = rd;
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        rd_chk(OFS_PERIOD, 32'h0000_2EDF, "period reset again");
        reg_acc(1'b1, OFS_PERIOD, saved);
        rd_chk(OFS_PERIOD, 32'h8005_0002, "period restored");
        reg_acc(1'b1, OFS_LEFT, 32'h8000_0001);
        rd_chk(OFS_LEFT, 32'h8000_0001, "left written");
    endtask : t_wrap

    // counts then verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    // main sequence
    initial begin
        n_mismatch    = 0;
        checked       = 0;
        nrst          = 1'b0;
        reg_req       = '0;
        running_state = 1'b0;
        {bit_tick, pkt_bit, sca_wr_done, sof_flag_clr} = 4'h0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_entry();
        t_budget();
        t_frame();
        t_wrap();
        summarize();
    end

    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        summarize();
    end

endmodule : usb_frame_timing_counters_tb
